/* verilog/ppcm_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - output mode drive: 00 hi-z, 01 p-ch od, 10 n-ch od, 11 cmos
// - input mode: 00 hi-z, 01 pull-down, 10 pull-up, 11 hi-z
// - direction bit 0 picks output meaning, 1 picks input meaning
// - reset clears drive and function registers to zero
// - drive and function registers take byte and word accesses
// - pin 7: 00 gpio, 01 converter sensor resistor, else prohibited
// - pin 6: 00 gpio, 01 ref resistor, 10 serial data out
// - pin 5: 00 gpio, 01 ref capacitor, 10 serial clock
// - pin 4: 00 gpio, 01 oscillation input, 10 serial data in
// - pin 3: 00 gpio, 01 uart transmit, 10 pwm output
// - pin 2: 00 gpio, 01 uart receive, 10 serial data out
// - pin 1: 00 gpio, 01 i2c clock, 10 serial clock
// - pin 0: 00 gpio, 01 i2c data, 10 serial data in
// - function select is bit n of both function registers
// - prohibited select in output mode ignores data, uses a low value
// - output mode drives the data register bit
// - input mode data read returns the sampled pin level
// - during conversion pins 4 to 7 belong to the converter
// - high registers sit one byte above the low registers
module ppcm_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// special function register bus
	input wire ppcm_pkg::ppcm_sfr_req_t sfr_req,
	output logic [15:0] sfr_rdata,
	// data and direction registers held outside
	input wire logic [7:0] port_data_register,
	input wire logic [7:0] port_direction_register,
	output logic [7:0] port_data_read,
	// external pins
	input wire logic [7:0] pin_in,
	output ppcm_pkg::ppcm_pad_t pad,
	// on-chip peripherals
	input wire ppcm_pkg::ppcm_periph_out_t periph_out,
	output ppcm_pkg::ppcm_periph_in_t periph_in,
	// rc oscillation converter
	input wire logic conversion_busy,
	input wire ppcm_pkg::ppcm_conv_drive_t conv_drive
);
	import ppcm_pkg::*;

	// ********************************************************
	// register file
	// ********************************************************
	logic [7:0] pin_drive_select_low;
	logic [7:0] pin_drive_select_high;
	logic [7:0] pin_function_select_low;
	logic [7:0] pin_function_select_high;
	logic wr_drive_low;
	logic wr_drive_high;
	logic wr_func_low;
	logic wr_func_high;
	logic [7:0] high_wdata;

	// a word access only counts at the even address; odd word is ignored
	// high one byte up
	assign wr_drive_low = sfr_req.wr && sfr_req.addr == ADDR_DRIVE_LOW;
	assign wr_drive_high = sfr_req.wr && (sfr_req.word ?
		sfr_req.addr == ADDR_DRIVE_LOW : sfr_req.addr == ADDR_DRIVE_HIGH);
	assign wr_func_low = sfr_req.wr && sfr_req.addr == ADDR_FUNC_LOW;
	assign wr_func_high = sfr_req.wr && (sfr_req.word ?
		sfr_req.addr == ADDR_FUNC_LOW : sfr_req.addr == ADDR_FUNC_HIGH);
	assign high_wdata = sfr_req.word ? sfr_req.wdata[15:8] :
		sfr_req.wdata[7:0];

	// drive select pair
	// reset to zero
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pin_drive_select_low <= RESET_BYTE;
			pin_drive_select_high <= RESET_BYTE;
		end else begin
			if (wr_drive_low) begin
				pin_drive_select_low <= sfr_req.wdata[7:0];
			end
			if (wr_drive_high) begin
				pin_drive_select_high <= high_wdata;
			end
		end
	end

	// function select pair
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pin_function_select_low <= RESET_BYTE;
			pin_function_select_high <= RESET_BYTE;
		end else begin
			if (wr_func_low) begin
				pin_function_select_low <= sfr_req.wdata[7:0];
			end
			if (wr_func_high) begin
				pin_function_select_high <= high_wdata;
			end
		end
	end

	// read data holds until the next read; unmapped reads give zero
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sfr_rdata <= READ_IDLE;
		end else if (sfr_req.rd) begin
			if (sfr_req.word) begin
				case (sfr_req.addr)
					ADDR_DRIVE_LOW: sfr_rdata <= {pin_drive_select_high,
						pin_drive_select_low};
					ADDR_FUNC_LOW: sfr_rdata <= {pin_function_select_high,
						pin_function_select_low};
					default: sfr_rdata <= READ_IDLE;
				endcase
			end else begin
				case (sfr_req.addr)
					ADDR_DRIVE_LOW: sfr_rdata <= {8'h00, pin_drive_select_low};
					ADDR_DRIVE_HIGH: sfr_rdata <= {8'h00, pin_drive_select_high};
					ADDR_FUNC_LOW: sfr_rdata <= {8'h00, pin_function_select_low};
					ADDR_FUNC_HIGH: sfr_rdata <= {8'h00,
						pin_function_select_high};
					default: sfr_rdata <= READ_IDLE;
				endcase
			end
		end
	end

	// ********************************************************
	// alternate function routing
	// ********************************************************
	logic [7:0] alt_second;
	logic [7:0] alt_third;
	logic [7:0] owned;
	logic [7:0] conv_out8;
	logic [7:0] conv_oe8;
	wire logic [7:0] next_out, next_oe, next_pu, next_pd;

	assign conv_out8 = {conv_drive.out, 4'h0};
	assign conv_oe8 = {conv_drive.oe, 4'h0};

	// input-only functions have nothing to drive, so the data bit is used
	// pin 7 sensor
	assign alt_second = {conv_drive.out, periph_out.uart0_transmit,
		port_data_register[2], periph_out.i2c0_clock_out,
		periph_out.i2c0_data_out};
	assign alt_third = {1'b0, periph_out.serial_port0_data_out,
		periph_out.serial_port0_clock_out, port_data_register[4],
		periph_out.output_a, periph_out.serial_port0_data_out,
		periph_out.serial_port0_clock_out, port_data_register[0]};

	// ********************************************************
	// per-pin drive decode
	// ********************************************************
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			logic [1:0] drive_sel;
			logic [1:0] func_sel;
			logic bad_sel;
			logic value;
			logic pin_out, pin_oe, pin_pu, pin_pd;
			// bit n of each drive register
			assign drive_sel = {pin_drive_select_high[i],
				pin_drive_select_low[i]};
			// bit n of each function register
			assign func_sel = {pin_function_select_high[i],
				pin_function_select_low[i]};
			assign bad_sel = func_sel == FUNC_BAD ||
				(func_sel == FUNC_THIRD && !THIRD_ALLOWED[i]);
			assign owned[i] = CONVERTER_PINS[i] &&
				(conversion_busy || func_sel == FUNC_SECOND);

			// value to present at the pin before the drive type
			always_comb begin
				if (bad_sel) begin
					value = 1'b0;
				end else if (func_sel == FUNC_GPIO) begin
					value = port_data_register[i];
				end else if (func_sel == FUNC_SECOND) begin
					value = alt_second[i];
				end else begin
					value = alt_third[i];
				end
			end

			// drive type and pulls; open drain halves switch by oe only
			always_comb begin
				pin_out = 1'b0;
				pin_oe = 1'b0;
				pin_pu = 1'b0;
				pin_pd = 1'b0;
				if (port_direction_register[i] == DIR_OUTPUT) begin
					case (drive_sel)
						DRIVE_HIZ: pin_oe = 1'b0;
						DRIVE_PCH: begin
							pin_out = 1'b1;
							pin_oe = value;
						end
						DRIVE_NCH: pin_oe = !value;
						DRIVE_CMOS: begin
							pin_out = value;
							pin_oe = 1'b1;
						end
						default: pin_oe = 1'b0;
					endcase
				end else begin
					pin_pu = drive_sel == INPUT_PULL_UP;
					pin_pd = drive_sel == INPUT_PULL_DOWN;
				end
				if (owned[i]) begin
					pin_out = conv_out8[i];
					pin_oe = conv_oe8[i];
				end
			end
			assign next_out[i] = pin_out;
			assign next_oe[i] = pin_oe;
			assign next_pu[i] = pin_pu;
			assign next_pd[i] = pin_pd;
		end
	endgenerate

	// pads are registered so the pins never glitch on decode changes
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pad <= '0;
		end else begin
			pad <= '{out: next_out, oe: next_oe, pull_up: next_pu,
				pull_down: next_pd};
		end
	end

	// ********************************************************
	// pin readback and peripheral inputs
	// ********************************************************
	// input mode reads pins
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			port_data_read <= RESET_BYTE;
		end else begin
			port_data_read <= (port_direction_register & pin_in) |
				(~port_direction_register & port_data_register);
		end
	end

	// unselected inputs sit at the idle level of each function
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			periph_in <= '0;
		end else begin
			periph_in.uart0_receive <= g_pin[2].func_sel == FUNC_SECOND ?
				pin_in[2] : 1'b1;
			periph_in.serial_port0_data_in <=
				(g_pin[0].func_sel == FUNC_THIRD && pin_in[0]) ||
				(g_pin[4].func_sel == FUNC_THIRD && pin_in[4]);
			periph_in.serial_port0_clock_in <=
				(g_pin[1].func_sel == FUNC_THIRD && pin_in[1]) ||
				(g_pin[5].func_sel == FUNC_THIRD && pin_in[5]);
			periph_in.i2c0_clock_in <= g_pin[1].func_sel == FUNC_SECOND ?
				pin_in[1] : 1'b1;
			periph_in.i2c0_data_in <= g_pin[0].func_sel == FUNC_SECOND ?
				pin_in[0] : 1'b1;
			// pulls left as software set them
			periph_in.converter1_osc_input <= owned[4] && pin_in[4];
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	property p_cmos_follows_data;
		port_direction_register[3] == DIR_OUTPUT &&
		g_pin[3].drive_sel == DRIVE_CMOS && g_pin[3].func_sel == FUNC_GPIO
		|=> pad.oe[3] && pad.out[3] == $past(port_data_register[3]);
	endproperty
	a_cmos_follows_data: assert property (p_cmos_follows_data)
		else $error("cmos pin does not follow data");

	property p_nch_release_high;
		port_direction_register[0] == DIR_OUTPUT &&
		g_pin[0].drive_sel == DRIVE_NCH && g_pin[0].func_sel == FUNC_GPIO
		&& port_data_register[0] |=> !pad.oe[0];
	endproperty
	a_nch_release_high: assert property (p_nch_release_high)
		else $error("n-channel pin drives on a high");

	property p_pull_up_input;
		port_direction_register[1] && g_pin[1].drive_sel == INPUT_PULL_UP
		|=> pad.pull_up[1] && !pad.pull_down[1] && !pad.oe[1];
	endproperty
	a_pull_up_input: assert property (p_pull_up_input)
		else $error("pull-up not applied");

	property p_prohibited_low;
		port_direction_register[2] == DIR_OUTPUT &&
		g_pin[2].drive_sel == DRIVE_CMOS && g_pin[2].func_sel == FUNC_BAD
		|=> pad.oe[2] && !pad.out[2];
	endproperty
	a_prohibited_low: assert property (p_prohibited_low)
		else $error("prohibited select not held low");

	property p_uart_tx_route;
		port_direction_register[3] == DIR_OUTPUT &&
		g_pin[3].drive_sel == DRIVE_CMOS &&
		g_pin[3].func_sel == FUNC_SECOND
		|=> pad.out[3] == $past(periph_out.uart0_transmit);
	endproperty
	a_uart_tx_route: assert property (p_uart_tx_route)
		else $error("uart transmit not routed");

	property p_converter_owns;
		conversion_busy |=> pad.oe[7:4] == $past(conv_drive.oe);
	endproperty
	a_converter_owns: assert property (p_converter_owns)
		else $error("converter does not own upper pins");

	property p_input_readback;
		port_direction_register[5] |=> port_data_read[5] == $past(pin_in[5]);
	endproperty
	a_input_readback: assert property (p_input_readback)
		else $error("input readback wrong");

	property p_word_write;
		sfr_req.wr && sfr_req.word && sfr_req.addr == ADDR_FUNC_LOW
		|=> pin_function_select_low == $past(sfr_req.wdata[7:0]) &&
		pin_function_select_high == $past(sfr_req.wdata[15:8]);
	endproperty
	a_word_write: assert property (p_word_write)
		else $error("word write split wrong");

	property p_byte_high_write;
		sfr_req.wr && !sfr_req.word && sfr_req.addr == ADDR_DRIVE_HIGH
		|=> pin_drive_select_high == $past(sfr_req.wdata[7:0]) &&
		$stable(pin_drive_select_low);
	endproperty
	a_byte_high_write: assert property (p_byte_high_write)
		else $error("high byte write wrong");

	c_word_write: cover property (sfr_req.wr && sfr_req.word);
	c_conversion: cover property (conversion_busy ##1 !conversion_busy);
	c_prohibited: cover property (g_pin[2].func_sel == FUNC_BAD);
	c_pull_down: cover property (pad.pull_down[0]);

endmodule : ppcm_top

/* verilog/ppcm_pkg.sv */
package ppcm_pkg;

	// ********************************************************
	// register map and reset values
	// ********************************************************
	localparam logic [15:0] ADDR_DRIVE_LOW = 16'hF222;
	localparam logic [15:0] ADDR_DRIVE_HIGH = 16'hF223;
	localparam logic [15:0] ADDR_FUNC_LOW = 16'hF224;
	localparam logic [15:0] ADDR_FUNC_HIGH = 16'hF225;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] READ_IDLE = 16'h0000;

	// ********************************************************
	// field encodings
	// ********************************************************
	localparam logic DIR_OUTPUT = 1'b0;
	localparam logic [1:0] DRIVE_HIZ = 2'h0;
	localparam logic [1:0] DRIVE_PCH = 2'h1;
	localparam logic [1:0] DRIVE_NCH = 2'h2;
	localparam logic [1:0] DRIVE_CMOS = 2'h3;
	localparam logic [1:0] INPUT_PULL_DOWN = 2'h1;
	localparam logic [1:0] INPUT_PULL_UP = 2'h2;
	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_SECOND = 2'h1;
	localparam logic [1:0] FUNC_THIRD = 2'h2;
	localparam logic [1:0] FUNC_BAD = 2'h3;
	// pin 7 has no third function
	localparam logic [7:0] THIRD_ALLOWED = 8'h7F;
	// pins taken over by the rc converter
	localparam logic [7:0] CONVERTER_PINS = 8'hF0;

	// ********************************************************
	// carriers
	// ********************************************************
	typedef struct packed {
		logic rd;
		logic wr;
		logic word;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ppcm_sfr_req_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
	} ppcm_pad_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} ppcm_conv_drive_t;

	typedef struct packed {
		logic uart0_transmit;
		logic output_a;
		logic serial_port0_data_out;
		logic serial_port0_clock_out;
		logic i2c0_clock_out;
		logic i2c0_data_out;
	} ppcm_periph_out_t;

	typedef struct packed {
		logic uart0_receive;
		logic serial_port0_data_in;
		logic serial_port0_clock_in;
		logic i2c0_clock_in;
		logic i2c0_data_in;
		logic converter1_osc_input;
	} ppcm_periph_in_t;

endpackage : ppcm_pkg

/* sim/ppcm_far_side.sv */
`timescale 1ns/1ps
// ********************************
// board wiring and far-side drivers
// ********************************
module ppcm_far_side
	import ppcm_pkg::*;
(
	// clock
	input wire logic core_clk,
	// port side
	input wire ppcm_pkg::ppcm_pad_t pad,
	output logic [7:0] pin_in,
	// board drivers set by the bench
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val
);
	logic [7:0] float_pat;

	// undriven pins wander so a stale level never looks valid
	always_ff @(posedge core_clk) begin
		float_pat <= (float_pat === 8'h55) ? 8'hAA : 8'h55;
	end

	// port driver wins, then the board, then the pull resistors
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad.oe[i])
				pin_in[i] = pad.out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pad.pull_up[i] | pad.pull_down[i])
				pin_in[i] = pad.pull_up[i];
			else
				pin_in[i] = float_pat[i];
		end
	end
endmodule : ppcm_far_side

/* sim/ppcm_top_tb.sv */
`timescale 1ns/1ps
module ppcm_top_tb;
	import ppcm_pkg::*;
	typedef struct packed {
		ppcm_pad_t pad;
		logic [7:0] pdr;
		ppcm_periph_in_t fn;
	} ppcm_obs_t;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	ppcm_sfr_req_t sfr_req = '0;
	logic [15:0] sfr_rdata;
	logic [7:0] dat = '0, dir = '0, pin_in, port_data_read, ext_en, ext_val;
	logic [7:0] d0, d1, f0, f1;
	ppcm_pad_t pad;
	ppcm_periph_out_t pout = '0;
	ppcm_periph_in_t periph_in;
	logic busy = 1'b0;
	ppcm_conv_drive_t conv = '0;
	logic [7:0] regs [4] = '{default: 8'h00};
	logic [15:0] rd_q [$];
	ppcm_obs_t obs_q [$];
	event obs_ev;
	int mismatches = 0, n_compared = 0, cycles = 0;
	logic hit;

	ppcm_top u_ppcm_top (.core_clk(core_clk), .resetn(resetn),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.port_data_register(dat), .port_direction_register(dir),
		.port_data_read(port_data_read), .pin_in(pin_in), .pad(pad),
		.periph_out(pout), .periph_in(periph_in),
		.conversion_busy(busy), .conv_drive(conv));
	ppcm_far_side u_ppcm_far_side (.core_clk(core_clk), .pad(pad),
		.pin_in(pin_in), .ext_en(ext_en), .ext_val(ext_val));

	// ********************************
	// clock, timeout and verdict
	// ********************************
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	// about 760 cycles of traffic expected, so 5000 means a hang
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	// ********************************
	// register shadow and bus driver
	// ********************************
	function automatic logic [15:0] exp_read(logic w, logic [15:0] a);
		logic [1:0] k;
		k = a[1:0] + 2'h2;
		if (a < ADDR_DRIVE_LOW || a > ADDR_FUNC_HIGH) return READ_IDLE;
		if (!w) return {8'h00, regs[k]};
		// odd word access is refused
		if (a[0]) return READ_IDLE;
		return {regs[k + 2'h1], regs[k]};
	endfunction : exp_read
	// requests change at the falling edge and stay one full cycle
	task automatic bus_op(logic rd, logic wr, logic w, logic [15:0] a,
		logic [15:0] d);
		logic [1:0] k;
		k = a[1:0] + 2'h2;
		@(negedge core_clk);
		sfr_req = '{rd: rd, wr: wr, word: w, addr: a, wdata: d};
		if (rd) rd_q.push_back(exp_read(w, a));
		if (wr && a >= ADDR_DRIVE_LOW && a <= ADDR_FUNC_HIGH) begin
			if (!w) regs[k] = d[7:0];
			else if (!a[0]) {regs[k + 2'h1], regs[k]} = d;
		end
	endtask : bus_op

	// ********************************
	// pin expectations
	// ********************************
	function automatic ppcm_obs_t expect_pins();
		ppcm_obs_t e;
		logic [1:0] c;
		logic [1:0] m [8];
		logic v, o;
		logic [7:0] lvl;
		e = '0;
		for (int i = 0; i < 8; i++) begin
			c = {regs[1][i], regs[0][i]};
			m[i] = {regs[3][i], regs[2][i]};
			case ({i[2:0], m[i]})
				5'h01: v = pout.i2c0_data_out;
				5'h05: v = pout.i2c0_clock_out;
				5'h06: v = pout.serial_port0_clock_out;
				5'h0A: v = pout.serial_port0_data_out;
				5'h0D: v = pout.uart0_transmit;
				5'h0E: v = pout.output_a;
				5'h16: v = pout.serial_port0_clock_out;
				5'h1A: v = pout.serial_port0_data_out;
				default: v = dat[i];
			endcase
			if (m[i] == 2'h3 || (i == 7 && m[i] == 2'h2)) v = 1'b0;
			if (dir[i]) begin
				e.pad.pull_down[i] = (c == 2'h1);
				e.pad.pull_up[i] = (c == 2'h2);
			end else begin
				o = (c == 2'h3) || (c == 2'h1 && v) || (c == 2'h2 && !v);
				e.pad.oe[i] = o;
				e.pad.out[i] = o & v;
			end
			// converter owns pins 4 to 7
			if (i >= 4 && (busy || m[i] == 2'h1)) begin
				e.pad.oe[i] = conv.oe[i - 4];
				e.pad.out[i] = conv.oe[i - 4] & conv.out[i - 4];
			end
			lvl[i] = e.pad.oe[i] ? e.pad.out[i] :
				ext_en[i] ? ext_val[i] : e.pad.pull_up[i];
			e.pdr[i] = dir[i] ? lvl[i] : dat[i];
		end
		e.fn.uart0_receive = (m[2] == 2'h1) ? lvl[2] : 1'b1;
		e.fn.serial_port0_data_in = (m[0] == 2'h2 && lvl[0]) ||
			(m[4] == 2'h2 && lvl[4]);
		e.fn.serial_port0_clock_in = (m[1] == 2'h2 && lvl[1]) ||
			(m[5] == 2'h2 && lvl[5]);
		e.fn.i2c0_clock_in = (m[1] == 2'h1) ? lvl[1] : 1'b1;
		e.fn.i2c0_data_in = (m[0] == 2'h1) ? lvl[0] : 1'b1;
		// oscillation input only while the converter owns pin 4
		e.fn.converter1_osc_input = (busy || m[4] == 2'h1) && lvl[4];
		return e;
	endfunction : expect_pins
	// the last request keeps its full cycle before the bus goes idle
	task automatic expect_now();
		@(negedge core_clk);
		sfr_req = '0;
		repeat (3) @(negedge core_clk);
		obs_q.push_back(expect_pins());
		->obs_ev;
	endtask : expect_now

	// ********************************
	// output watchers
	// ********************************
	task automatic compare_read(logic [15:0] want);
		n_compared++;
		if (sfr_rdata !== want) begin
			mismatches++;
			$display("unexpected read at %0t: %h", $time, sfr_rdata);
		end
	endtask : compare_read
	task automatic compare_pins(ppcm_obs_t want);
		ppcm_obs_t got;
		got = {pad.out & pad.oe, pad.oe, pad.pull_up, pad.pull_down,
			port_data_read, periph_in};
		n_compared++;
		if (got !== want) begin
			mismatches++;
			$display("unexpected pins at %0t: %h", $time, got);
		end
	endtask : compare_pins
	initial begin
		forever begin
			@(posedge core_clk);
			hit = (sfr_req.rd === 1'b1) && resetn;
			@(negedge core_clk);
			if (hit)
				compare_read(rd_q.pop_front());
		end
	end
	initial begin
		forever begin
			@(obs_ev);
			compare_pins(obs_q.pop_front());
		end
	end

	// ********************************
	// main sequence
	// ********************************
	initial begin
		void'($urandom(32'h79DF));
		ext_en = 8'hFF;
		ext_val = 8'($urandom);
		repeat (12) @(negedge core_clk);
		resetn = 1'b1;
		expect_now();
		for (int a = 0; a < 6; a++)
			bus_op(1'b1, 1'b0, a[0], ADDR_DRIVE_LOW + 16'(a), '0);
		// back to back writes, a refused odd word, an unmapped byte
		bus_op(1'b0, 1'b1, 1'b1, ADDR_DRIVE_LOW, 16'($urandom));
		bus_op(1'b0, 1'b1, 1'b1, ADDR_FUNC_LOW, 16'($urandom));
		bus_op(1'b0, 1'b1, 1'b0, ADDR_DRIVE_HIGH, 16'($urandom));
		bus_op(1'b0, 1'b1, 1'b1, ADDR_FUNC_HIGH, 16'($urandom));
		bus_op(1'b0, 1'b1, 1'b0, 16'hF226, 16'($urandom));
		for (int a = -2; a < 6; a++)
			bus_op(1'b1, 1'b0, a[0], ADDR_DRIVE_LOW + 16'(a), '0);
		bus_op(1'b1, 1'b0, 1'b1, ADDR_FUNC_LOW, '0);
		for (int n = 0; n < 120; n++) begin
			dat = 8'($urandom);
			dir = 8'($urandom);
			busy = ($urandom_range(3) == 0);
			conv = 8'($urandom);
			pout = 6'($urandom);
			ext_val = 8'($urandom);
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			// every select on every pin, prohibited ones included
			f0 = 8'($urandom);
			f1 = 8'($urandom);
			for (int i = 4; i < 8; i++) begin
				if (busy || {f1[i], f0[i]} == 2'h1) begin
					dir[i] = 1'b1;
					d0[i] = 1'b0;
					d1[i] = 1'b0;
				end
			end
			// board lets go only where a pull holds the pin
			ext_en = ~(dir & (d0 ^ d1));
			bus_op(1'b0, 1'b1, 1'b1, ADDR_DRIVE_LOW, {d1, d0});
			bus_op(1'b0, 1'b1, 1'b1, ADDR_FUNC_LOW, {f1, f0});
			expect_now();
		end
		repeat (2) @(negedge core_clk);
		report_and_stop();
	end
endmodule : ppcm_top_tb
